// ### hw/mux_scan_pkg.sv
// constants for the isolated multiplexer scan control block
package mux_scan_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 2;
    localparam int CHAN_W = 4;
    localparam int BANK_W = 3;
    localparam int CHAN_CNT = 16;
    localparam int GAIN_W = 5;
    localparam int SETTLE_W = 24;
    // register indices selected by the address handler
    localparam logic [1:0] REG_CONFIG = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam logic [1:0] REG_ID = 2'h2;
    // configuration and status word fields
    localparam int CFG_GAIN_LSB = 0;
    localparam int CFG_NARROW = 5;
    localparam int CFG_FOUR_WIRE = 6;
    localparam int CFG_TEMP = 7;
    localparam int CFG_SHUNT = 8;
    localparam int CFG_AUTO_ZERO = 9;
    localparam int STAT_BUSY = 0;
    // gain codes 0..16 run 0.01 .. 2000 in 1-2-5 steps
    localparam logic [4:0] GAIN_MAX = 5'h10;
    // arbitrary identification value
    localparam logic [15:0] MODULE_ID_DEFAULT = 16'h005C;
    // synchroniser lane positions
    localparam int SY_SCLK = 0;
    localparam int SY_DIN = 1;
    localparam int SY_DAS = 2;
    localparam int SY_SLOT = 3;
    localparam int SY_STB = 4;
    localparam int SY_W = 5;
    localparam int CLK_HZ = 25_000_000;
    localparam int SETTLE_TIME_US = 1000;
    localparam int SETTLE_CYC_DEFAULT = SETTLE_TIME_US * (CLK_HZ / 1_000_000);
endpackage

// ### hw/mux_scan_control.sv
// serial-configured channel scan control for the sixteen-channel isolated mux
//
// Overview of operation
// - address handler register picks the target of following serial data transfers.
// - configuration register holds gain, shunt, filter, scan mode, sensor, auto-zero.
// - gain code selects one of seventeen gains, 0.01 to 2000, 1-2-5 steps.
// - status register shows whether configuration is still being applied.
// - read-only module identification code readable over the serial bus.
// - two-wire mode: all sixteen channels sense, exactly one routed to amplifier.
// - four-wire mode: only channels 0-7 sense, exactly one routed.
// - four-wire mode: channels 8-15 carry current, exactly one, in lockstep.
// - filter control chooses 4 kHz or 4 Hz low-pass bandwidth.
// - temperature select routes the terminal sensor instead of an input channel.
// - shunt calibration enable switches the shunt resistor in or out.
// - auto-zero selection lets amplifier offset be measured and nulled.
// - each scan strobe pulse advances the multiplexer to the next channel.
// - data/address select line marks serial bits as data or address.
// - auto-zero disconnects relay mux and grounds amplifier inputs.
`timescale 1ns/10ps
module mux_scan_control
    import mux_scan_pkg::*;
#(
    parameter int SETTLE_CYC = mux_scan_pkg::SETTLE_CYC_DEFAULT,
    parameter logic [15:0] MODULE_ID = mux_scan_pkg::MODULE_ID_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic serial_shift_clock,
    input wire logic serial_in_line,
    input wire logic data_address_select,
    input wire logic controller_slot_select,
    input wire logic channel_advance_strobe,
    output logic serial_out_line,
    output logic [mux_scan_pkg::GAIN_W-1:0] gain_select,
    output logic filter_narrow,
    output logic four_wire_mode,
    output logic temp_sensor_route,
    output logic shunt_cal_enable,
    output logic auto_zero_select,
    output logic amp_mux_connect,
    output logic amp_input_ground,
    output logic [mux_scan_pkg::CHAN_CNT-1:0] sense_route,
    output logic [mux_scan_pkg::CHAN_CNT-1:0] current_route,
    output logic config_busy
);
    import mux_scan_pkg::*;

    typedef struct packed {
        logic [SY_W-1:0] s1;
        logic [SY_W-1:0] s2;
        logic [SY_W-1:0] prev;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] shin;
        logic [4:0] bitcnt;
        logic [DATA_W-1:0] shout;
        logic [GAIN_W-1:0] gain;
        logic narrow;
        logic four;
        logic temp;
        logic shunt;
        logic az;
        logic [CHAN_W-1:0] chan;
        logic [SETTLE_W-1:0] settle;
        logic busy;
        logic [CHAN_CNT-1:0] sense;
        logic [CHAN_CNT-1:0] current;
        logic temp_route;
        logic mux_link;
        logic amp_gnd;
    } state_t;

    localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(SETTLE_CYC - 1);
    localparam logic [4:0] LAST_BIT = 5'(DATA_W - 1);

    state_t q;
    state_t d;
    logic sclk_rise;
    logic sclk_fall;
    logic stb_rise;
    logic module_sel;
    logic addr_take;
    logic write_go;
    logic [DATA_W-1:0] wr_word;
    logic [DATA_W-1:0] rd_word;

    always_comb begin
        d = q;
        d.s1 = {channel_advance_strobe, controller_slot_select, data_address_select,
                serial_in_line, serial_shift_clock};
        d.s2 = q.s1;
        d.prev = q.s2;
        sclk_rise = q.s2[SY_SCLK] & ~q.prev[SY_SCLK];
        sclk_fall = ~q.s2[SY_SCLK] & q.prev[SY_SCLK];
        stb_rise = q.s2[SY_STB] & ~q.prev[SY_STB];
        // high means a module is addressed, low means the slot 0 controller
        module_sel = q.s2[SY_SLOT];
        addr_take = 1'b0;
        write_go = 1'b0;
        wr_word = {q.shin[DATA_W-2:0], q.s2[SY_DIN]};
        if (module_sel && sclk_rise) begin
            if (q.s2[SY_DAS]) begin
                // address bits restart any half-shifted data word
                d.addr = {q.addr[0], q.s2[SY_DIN]};
                d.bitcnt = '0;
                addr_take = 1'b1;
            end else begin
                d.shin = wr_word;
                d.bitcnt = q.bitcnt + 5'h01;
                if (q.bitcnt == LAST_BIT) begin
                    d.bitcnt = '0;
                    write_go = (q.addr == REG_CONFIG);
                end
            end
        end
        if (write_go) begin
            d.gain = (wr_word[CFG_GAIN_LSB +: GAIN_W] > GAIN_MAX) ? GAIN_MAX
                : wr_word[CFG_GAIN_LSB +: GAIN_W];
            d.narrow = wr_word[CFG_NARROW];
            d.four = wr_word[CFG_FOUR_WIRE];
            d.temp = wr_word[CFG_TEMP];
            d.shunt = wr_word[CFG_SHUNT];
            d.az = wr_word[CFG_AUTO_ZERO];
        end
        // a new write restarts settling even while busy
        if (write_go) begin
            d.busy = 1'b1;
            d.settle = SETTLE_LOAD;
        end else if (q.busy) begin
            if (q.settle == '0) begin
                d.busy = 1'b0;
            end else begin
                d.settle = q.settle - SETTLE_W'(1);
            end
        end
        if (d.addr == REG_CONFIG) begin
            rd_word = '0;
            rd_word[CFG_GAIN_LSB +: GAIN_W] = d.gain;
            rd_word[CFG_NARROW] = d.narrow;
            rd_word[CFG_FOUR_WIRE] = d.four;
            rd_word[CFG_TEMP] = d.temp;
            rd_word[CFG_SHUNT] = d.shunt;
            rd_word[CFG_AUTO_ZERO] = d.az;
        end else if (d.addr == REG_STATUS) begin
            rd_word = '0;
            rd_word[STAT_BUSY] = d.busy;
        end else if (d.addr == REG_ID) begin
            rd_word = MODULE_ID;
        end else begin
            rd_word = '0;
        end
        // readback is snapshotted when the address is taken
        if (addr_take) begin
            d.shout = rd_word;
        end else if (module_sel && sclk_fall && !q.s2[SY_DAS]) begin
            d.shout = {q.shout[DATA_W-2:0], 1'b0};
        end
        // any configuration write restarts the scan from channel 0
        if (write_go) begin
            d.chan = '0;
        end else if (stb_rise) begin
            if (q.four) begin
                d.chan = {1'b0, q.chan[BANK_W-1:0] + 3'h1};
            end else begin
                d.chan = q.chan + 4'h1;
            end
        end
        d.sense = '0;
        d.current = '0;
        d.mux_link = !d.az && !d.temp;
        d.amp_gnd = d.az;
        d.temp_route = d.temp && !d.az;
        if (d.four) begin
            d.current[{1'b1, d.chan[BANK_W-1:0]}] = 1'b1;
        end
        if (d.mux_link) begin
            if (d.four) begin
                d.sense[{1'b0, d.chan[BANK_W-1:0]}] = 1'b1;
            end else begin
                d.sense[d.chan] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign serial_out_line = q.shout[DATA_W-1];
    assign gain_select = q.gain;
    assign filter_narrow = q.narrow;
    assign four_wire_mode = q.four;
    assign temp_sensor_route = q.temp_route;
    assign shunt_cal_enable = q.shunt;
    assign auto_zero_select = q.az;
    assign amp_mux_connect = q.mux_link;
    assign amp_input_ground = q.amp_gnd;
    assign sense_route = q.sense;
    assign current_route = q.current;
    assign config_busy = q.busy;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    one_sense_a: assert property (q.mux_link |-> $onehot(q.sense))
        else $error("sense routing not one-hot");
    low_bank_a: assert property (q.four |-> q.sense[CHAN_CNT-1:CHAN_CNT/2] == '0)
        else $error("four-wire sense outside channels 0-7");
    current_pair_a: assert property (q.four && q.mux_link |->
        $onehot(q.current) && q.current == (q.sense << (CHAN_CNT / 2)))
        else $error("current channel not sense plus eight");
    busy_start_a: assert property (write_go |=> q.busy ##1 q.busy)
        else $error("busy not raised after config write");
    addr_shift_a: assert property (addr_take |=> q.addr == {$past(q.addr[0]),
        $past(q.s2[SY_DIN])})
        else $error("address bit not captured");
    slot_ignore_a: assert property (!module_sel |=> $stable(q.addr) && $stable(q.shin))
        else $error("serial bits taken for slot 0");
    advance_two_a: assert property (stb_rise && !write_go && !q.four |=>
        q.chan == $past(q.chan) + 4'h1)
        else $error("strobe did not advance channel");
    gain_range_a: assert property (q.gain <= GAIN_MAX)
        else $error("gain code out of range");
    zero_path_a: assert property (q.az |-> q.amp_gnd && !q.mux_link && q.sense == '0)
        else $error("auto-zero left mux connected");
    temp_path_a: assert property (q.temp && !q.az |-> q.temp_route && q.sense == '0)
        else $error("temperature route wrong");

    cfg_write_c: cover property (write_go ##1 q.busy);
    four_wrap_c: cover property (q.four && stb_rise && q.chan[BANK_W-1:0] == 3'h7);
    auto_zero_c: cover property ($rose(q.az));
endmodule // mux_scan_control

// ### verification/daq_board_model.sv
// acquisition-board controller model driving the serial link
`timescale 1ns/10ps
module daq_board_model (
    output logic sclk,
    output logic sdin,
    output logic das,
    output logic slot,
    input wire logic sdout
);
    initial begin
        {sclk, sdin, das, slot} = 4'h3;
    end
    // clock idles low; idle gap keeps a select change clear of the last fall
    task automatic frame(input logic sel, input int n, input logic [15:0] v,
        output logic [15:0] rd);
        rd = 16'h0000;
        #320 das = sel;
        for (int i = n - 1; i >= 0; i--) begin
            #80 sdin = v[i];
            #80 sclk = 1'b1;
            #160 rd[i] = sdout;
            sclk = 1'b0;
        end
        // released data line must not look held
        #80 sdin = ~sdin;
    endtask
    task automatic access(input logic s, input logic [1:0] a, input logic [15:0] w,
        output logic [15:0] rd);
        logic [15:0] nc;
        slot = s;
        frame(1'b1, 2, {14'h0000, a}, nc);
        frame(1'b0, 16, w, rd);
        // one idle step, so a following access never sets the select in the same step
        #80 slot = 1'b1;
    endtask
endmodule // daq_board_model

// ### verification/isolated_mux_scan_control_tb.sv
// self-checking bench for the mux scan control block
`timescale 1ns/10ps
module isolated_mux_scan_control_tb;
    import mux_scan_pkg::*;
    localparam logic [15:0] ID_VAL = 16'h0C3E; // arbitrary value
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic stb = 1'b0;
    wire logic sclk, sdin, das, slot, sdout;
    logic [4:0] gain;
    logic nar, fw, temp, shunt, az, conn, gnd, busy;
    logic [15:0] sense, cur, rd, w;
    int failures = 0;
    int num_checks = 0;
    int n, k;
    always #20 clk_sys = ~clk_sys;
    daq_board_model daq_board_model_inst (.sclk(sclk), .sdin(sdin), .das(das),
        .slot(slot), .sdout(sdout));
    mux_scan_control #(.SETTLE_CYC(64), .MODULE_ID(ID_VAL)) mux_scan_control_inst (
        .clk_sys(clk_sys), .srst(srst), .serial_shift_clock(sclk),
        .serial_in_line(sdin), .data_address_select(das),
        .controller_slot_select(slot), .channel_advance_strobe(stb),
        .serial_out_line(sdout), .gain_select(gain), .filter_narrow(nar),
        .four_wire_mode(fw), .temp_sensor_route(temp), .shunt_cal_enable(shunt),
        .auto_zero_select(az), .amp_mux_connect(conn), .amp_input_ground(gnd),
        .sense_route(sense), .current_route(cur), .config_busy(busy));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    function automatic logic [11:0] exp_cfg(logic [15:0] v);
        logic [4:0] g;
        g = (v[4:0] > GAIN_MAX) ? GAIN_MAX : v[4:0];
        return {g, v[9:5], ~v[9] & ~v[7], v[9]};
    endfunction
    task automatic check_state();
        logic [15:0] s;
        s = (w[9] | w[7]) ? 16'h0000 : 16'h0001 << (n % (w[6] ? 8 : 16));
        check(32'({gain, az, shunt, temp, fw, nar, conn, gnd}), 32'(exp_cfg(w)));
        check(32'(sense), 32'(s));
        check(32'(cur), 32'(w[6] ? 16'h0100 << (n % 8) : 16'h0000));
    endtask
    initial begin
        #1_000_000;
        failures++;
        final_report();
    end
    initial begin
        void'($urandom(35));
        repeat (2) @(negedge clk_sys);
        srst = 1'b0;
        repeat (3) @(negedge clk_sys);
        w = 16'h0000;
        n = 0;
        check_state();
        for (int it = 0; it < 8; it++) begin
            w = 16'($urandom);
            w[9:5] = {it == 3, w[8], it == 5, it[0], w[5]};
            w[4:0] = (it == 0) ? 5'h11 : (it == 1) ? GAIN_MAX : w[4:0] % 5'h11;
            daq_board_model_inst.access(1'b1, REG_CONFIG, w, rd);
            n = 0;
            repeat (2) @(negedge clk_sys);
            check(32'(busy), 32'h1);
            check_state();
            daq_board_model_inst.access(1'b1, REG_STATUS, 16'h0000, rd);
            check(32'(rd[STAT_BUSY]), 32'h1);
            // settle before sampling
            for (k = 0; busy !== 1'b0 && k < 200; k++) @(negedge clk_sys);
            if (k == 200) begin
                failures++;
                final_report();
            end
            repeat (int'($urandom_range(23, 9))) begin
                stb = 1'b1;
                repeat (3) @(negedge clk_sys);
                stb = 1'b0;
                repeat (3) @(negedge clk_sys);
                n++;
            end
            repeat (6) @(negedge clk_sys);
            check_state();
        end
        daq_board_model_inst.access(1'b0, REG_CONFIG, ~w, rd);
        check_state();
        daq_board_model_inst.access(1'b1, REG_STATUS, ~w, rd);
        check_state();
        check(32'(rd[STAT_BUSY]), 32'h0);
        daq_board_model_inst.access(1'b1, REG_ID, 16'h0000, rd);
        check(32'(rd), 32'(ID_VAL));
        final_report();
    end
endmodule // isolated_mux_scan_control_tb
